// File: inc/ccr_pkg.sv
// constants and types shared by the cache control register logic
package ccr_pkg;

   // register width and field positions
   localparam int unsigned CCR_W = 32;
   localparam int unsigned BIT_CACHE_ON = 31;
   localparam int unsigned BIT_SB_ON = 29;
   localparam int unsigned BIT_KEEP_VALID = 28;
   localparam int unsigned BIT_HALF_LOCK = 27;
   localparam int unsigned BIT_INVAL_ALL = 24;
   localparam int unsigned BIT_FILL_BUF = 10;
   localparam int unsigned DCM_LSB = 8;
   localparam int unsigned BIT_WR_PROT = 5;

   // value after reset and the bits that can be written (others read zero)
   localparam logic [31:0] CCR_RESET = 32'h0000_0000;
   localparam logic [31:0] CCR_WR_MASK = 32'hB900_0720;

   // cache mode encodings of the default mode field and region modes
   localparam logic [1:0] MODE_WRITE_THRU = 2'h0;
   localparam logic [1:0] MODE_COPYBACK = 2'h1;
   localparam logic [1:0] MODE_INHIB_PRECISE = 2'h2;
   localparam logic [1:0] MODE_INHIB_IMPRECISE = 2'h3;

   // structure counts
   localparam int unsigned NUM_WAYS = 4;
   localparam int unsigned SBUF_DEPTH = 4;
   localparam int unsigned DEF_NUM_SETS = 128;

   // least stall of a write that bypasses the store buffer, in cycles
   localparam logic [2:0] DIRECT_STALL_CYC = 3'h5;

   // replacement counter value after reset
   localparam logic [1:0] RR_RESET = 2'h0;

   // external write channel states
   typedef enum logic [1:0] {BUS_IDLE, BUS_SBUF, BUS_DIRECT} ccr_bus_st_t;

endpackage : ccr_pkg

// File: src/ccr_way_alloc.sv
// way choice for line allocation with round-robin replacement counter
`timescale 1ns/1ns
`default_nettype none
module ccr_way_alloc (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic half_lock,
   input wire logic alloc_go,
   input wire logic [ccr_pkg::NUM_WAYS-1:0] way_valid,
   output logic alloc_done,
   output logic [1:0] alloc_way
);
   import ccr_pkg::*;

   typedef struct packed {
      logic [1:0] rr;
      logic done;
      logic [1:0] way;
   } ccr_alloc_st_t;

   ccr_alloc_st_t s;
   ccr_alloc_st_t next_s;
   logic [1:0] low_free;
   logic any_free;

   // lowest invalid way over all four ways
   always_comb begin
      low_free = 2'h0;
      any_free = 1'b0;
      for (int i = NUM_WAYS - 1; i >= 0; i--) begin
         if (!way_valid[i]) begin
            low_free = 2'(i);
            any_free = 1'b1;
         end
      end
   end

   // choose a way and advance the counter when every candidate is valid
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (alloc_go) begin
         next_s.done = 1'b1;
         if (!half_lock) begin
            if (any_free) begin
               next_s.way = low_free; // RULE_08
            end else begin
               next_s.way = s.rr; // RULE_08
               next_s.rr = s.rr + 2'h1; // RULE_08
            end
         end else if (!way_valid[2]) begin
            next_s.way = 2'h2; // RULE_09 RULE_10
         end else if (!way_valid[3]) begin
            next_s.way = 2'h3; // RULE_09
         end else begin
            next_s.way = s.rr[1] ? 2'h3 : 2'h2; // RULE_09 RULE_20
            next_s.rr = {~s.rr[1], s.rr[0]}; // RULE_09 RULE_20
         end
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s <= '{rr: RR_RESET, done: 1'b0, way: 2'h0};
      end else begin
         s <= next_s;
      end
   end

   assign alloc_done = s.done;
   assign alloc_way = s.way;

endmodule : ccr_way_alloc
`default_nettype wire

// File: src/ccr_inval_seq.sv
// sequential clear of valid and modified bits over every set
`timescale 1ns/1ns
`default_nettype none
module ccr_inval_seq #(
   parameter int unsigned NUM_SETS = ccr_pkg::DEF_NUM_SETS,
   parameter int unsigned SET_W = $clog2(NUM_SETS)
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic start,
   output logic busy,
   output logic clr_we,
   output logic [SET_W-1:0] clr_set,
   output logic done
);
   import ccr_pkg::*;

   typedef struct packed {
      logic busy;
      logic [SET_W-1:0] idx;
      logic clr;
      logic [SET_W-1:0] set;
      logic done;
   } ccr_inv_st_t;

   localparam logic [SET_W-1:0] LAST_SET = SET_W'(NUM_SETS - 1);

   ccr_inv_st_t s;
   ccr_inv_st_t next_s;

   // walk the sets one per cycle, pulse done with the last clear
   always_comb begin
      next_s = s;
      next_s.clr = 1'b0;
      next_s.done = 1'b0;
      if (s.busy) begin
         next_s.clr = 1'b1; // RULE_12
         next_s.set = s.idx;
         if (s.idx == LAST_SET) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1; // RULE_13
         end else begin
            next_s.idx = s.idx + 1'b1;
         end
      end else if (start) begin
         next_s.busy = 1'b1; // RULE_12
         next_s.idx = '0;
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy = s.busy;
   assign clr_we = s.clr;
   assign clr_set = s.set;
   assign done = s.done;

endmodule : ccr_inval_seq
`default_nettype wire

// File: src/ccr_cache_ctrl.sv
// cache control register and the controller behaviour its fields steer
// Operation
// RULE_01 - reset clears the control register; cache arrays are not touched
// RULE_02 - cache_on low keeps the cache out of accesses, contents kept
// RULE_03 - store_buffer_on enables a four-entry fifo for deferred writes
// RULE_04 - store buffer off: such writes go straight to the bus each
// RULE_05 - precise inhibited accesses never use the store buffer
// RULE_06 - keep_valid_after_push low: push writes back if modified, invalidates
// RULE_07 - keep_valid_after_push high: push writes back if modified, stays valid
// RULE_08 - unlocked: lowest invalid way, else counter way, counter modulo-4
// RULE_09 - locked: lower invalid of ways 2,3, else counter high bit, modulo-2
// RULE_10 - locked: ways 0,1 never allocated, still hit and pushed
// RULE_11 - half_lock acts at once whenever written
// RULE_12 - writing invalidate_everything as one starts a pass over all sets
// RULE_13 - invalidate_everything clears itself when the pass ends
// RULE_14 - accesses stall while the invalidation pass runs
// RULE_15 - writing invalidate_everything as zero changes nothing in the cache
// RULE_16 - software should push modified lines before invalidating all
// RULE_17 - register written by control_move_instr, read and written by debug
// RULE_18 - write mode comes from matching region, else default_cache_mode
// RULE_19 - unbuffered write held until bus termination, five stall cycles
// RULE_20 - replacement counter is two bits, high bit picks way 2 or 3
`timescale 1ns/1ns
`default_nettype none
module ccr_cache_ctrl #(
   parameter int unsigned NUM_SETS = ccr_pkg::DEF_NUM_SETS,
   parameter int unsigned SET_W = $clog2(NUM_SETS),
   parameter int unsigned SB_DEPTH = ccr_pkg::SBUF_DEPTH
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic move_wr_en,
   input wire logic [31:0] move_wr_data,
   input wire logic dbg_wr_en,
   input wire logic [31:0] dbg_wr_data,
   output logic [31:0] cache_control_reg,
   input wire logic acc_req,
   input wire logic acc_wr,
   input wire logic [31:0] acc_addr,
   input wire logic [31:0] acc_data,
   input wire logic region_hit,
   input wire logic [1:0] region_mode,
   output logic acc_stall,
   output logic acc_ack,
   output logic cache_lookup_en,
   output logic bus_wr_req,
   output logic [31:0] bus_wr_addr,
   output logic [31:0] bus_wr_data,
   input wire logic bus_wr_done,
   input wire logic alloc_req,
   input wire logic [ccr_pkg::NUM_WAYS-1:0] way_valid,
   output logic alloc_ack,
   output logic alloc_done,
   output logic [1:0] alloc_way,
   input wire logic push_req,
   input wire logic push_line_modified,
   output logic push_ack,
   output logic push_writeback,
   output logic push_invalidate,
   output logic inval_clr_we,
   output logic [SET_W-1:0] inval_clr_set
);
   import ccr_pkg::*;

   localparam int unsigned PTR_W = $clog2(SB_DEPTH);
   localparam int unsigned CNT_W = $clog2(SB_DEPTH + 1);
   localparam logic [CNT_W-1:0] SB_FULL = CNT_W'(SB_DEPTH);

   typedef struct packed {
      logic [31:0] ccr;
      ccr_bus_st_t bus_st;
      logic [SB_DEPTH-1:0][31:0] sb_addr;
      logic [SB_DEPTH-1:0][31:0] sb_data;
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] rptr;
      logic [CNT_W-1:0] cnt;
      logic [2:0] dcnt;
      logic dseen;
      logic [31:0] bus_addr;
      logic [31:0] bus_data;
      logic push_wb;
      logic push_inv;
   } ccr_st_t;

   ccr_st_t s;
   ccr_st_t next_s;

   logic wr_any;
   logic [31:0] wr_val;
   logic inv_busy;
   logic inv_done;
   logic inv_clr;
   logic inv_active;
   logic inv_start;
   logic [1:0] eff_mode;
   logic use_sb;
   logic direct_wr;
   logic direct_release;
   logic sb_push;
   logic sb_pop;
   logic alloc_go;

   // register write source: debug wins a same-cycle collision
   assign wr_any = move_wr_en | dbg_wr_en; // RULE_17
   assign wr_val = dbg_wr_en ? dbg_wr_data : move_wr_data; // RULE_17

   // invalidation pass runs from start until its last set is cleared
   assign inv_active = inv_busy | inv_clr;
   assign inv_start = wr_any & wr_val[BIT_INVAL_ALL] & ~inv_busy; // RULE_12

   // mode of this access: matching region first, else default field
   assign eff_mode = region_hit ? region_mode :
                     s.ccr[DCM_LSB+1:DCM_LSB]; // RULE_18

   // store buffer takes write-through and imprecise inhibited writes
   assign use_sb = s.ccr[BIT_SB_ON] & acc_wr &
                   (eff_mode == MODE_WRITE_THRU ||
                    eff_mode == MODE_INHIB_IMPRECISE); // RULE_03 RULE_05

   // any other write that must reach the bus goes out on its own cycle
   assign direct_wr = acc_wr & ~use_sb &
                      (eff_mode != MODE_COPYBACK | ~s.ccr[BIT_CACHE_ON]); // RULE_04

   // an unbuffered write is let go after termination and the least stall
   assign direct_release = (s.bus_st == BUS_DIRECT) &
                           (s.dseen | bus_wr_done) &
                           (s.dcnt >= DIRECT_STALL_CYC); // RULE_19

   // stall decision for the core access port
   always_comb begin
      if (inv_active) begin
         acc_stall = acc_req; // RULE_14
      end else if (use_sb) begin
         acc_stall = acc_req & (s.cnt == SB_FULL); // RULE_03
      end else if (direct_wr) begin
         acc_stall = acc_req & ~direct_release; // RULE_19
      end else begin
         acc_stall = 1'b0;
      end
   end

   assign acc_ack = acc_req & ~acc_stall;

   // cache takes part in a lookup only when on and the mode is cacheable
   assign cache_lookup_en = acc_ack & s.ccr[BIT_CACHE_ON] &
                            ~eff_mode[1]; // RULE_02

   assign sb_push = acc_ack & use_sb;
   assign sb_pop = (s.bus_st == BUS_SBUF) & bus_wr_done;

   // allocation and push requests wait out an invalidation pass
   assign alloc_go = alloc_req & s.ccr[BIT_CACHE_ON] & ~inv_active; // RULE_02 RULE_14
   assign alloc_ack = alloc_go;
   assign push_ack = push_req & ~inv_active; // RULE_14

   // next state of register, store buffer, bus channel and push result
   always_comb begin
      next_s = s;
      next_s.push_wb = 1'b0;
      next_s.push_inv = 1'b0;

      // register write; the invalidate bit is set by a one and only
      // cleared by the end of the pass, a new start winning over the end
      if (wr_any) begin
         next_s.ccr = wr_val & CCR_WR_MASK; // RULE_17 RULE_11
         next_s.ccr[BIT_INVAL_ALL] = wr_val[BIT_INVAL_ALL] |
                                     (s.ccr[BIT_INVAL_ALL] & ~inv_done); // RULE_15
      end else if (inv_done) begin
         next_s.ccr[BIT_INVAL_ALL] = 1'b0; // RULE_13
      end

      // line push: write back if modified, invalidate unless kept valid
      if (push_ack) begin
         next_s.push_wb = push_line_modified; // RULE_06 RULE_07
         next_s.push_inv = ~s.ccr[BIT_KEEP_VALID]; // RULE_06 RULE_07
      end

      // store buffer fill
      if (sb_push) begin
         next_s.sb_addr[s.wptr] = acc_addr; // RULE_03
         next_s.sb_data[s.wptr] = acc_data; // RULE_03
         next_s.wptr = s.wptr + 1'b1;
      end
      if (sb_pop) begin
         next_s.rptr = s.rptr + 1'b1;
      end
      if (sb_push && !sb_pop) begin
         next_s.cnt = s.cnt + 1'b1;
      end else if (sb_pop && !sb_push) begin
         next_s.cnt = s.cnt - 1'b1;
      end

      // external write channel: buffered writes drain first, in order
      case (s.bus_st)
         BUS_IDLE: begin
            if (s.cnt != '0) begin
               next_s.bus_st = BUS_SBUF;
               next_s.bus_addr = s.sb_addr[s.rptr];
               next_s.bus_data = s.sb_data[s.rptr];
            end else if (acc_req && direct_wr && !inv_active) begin
               next_s.bus_st = BUS_DIRECT; // RULE_04
               next_s.bus_addr = acc_addr;
               next_s.bus_data = acc_data;
               next_s.dcnt = 3'h1;
               next_s.dseen = 1'b0;
            end
         end
         BUS_SBUF: begin
            if (bus_wr_done) begin
               next_s.bus_st = BUS_IDLE;
            end
         end
         BUS_DIRECT: begin
            if (s.dcnt < DIRECT_STALL_CYC) begin
               next_s.dcnt = s.dcnt + 3'h1; // RULE_19
            end
            if (bus_wr_done) begin
               next_s.dseen = 1'b1;
            end
            if (direct_release) begin
               next_s.bus_st = BUS_IDLE;
            end
         end
         default: begin
            next_s.bus_st = BUS_IDLE;
         end
      endcase
   end

   // state register; reset clears the control register and all other controller state
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         s <= '0;
         s.ccr <= CCR_RESET; // RULE_01
         s.bus_st <= BUS_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // way choice follows the lock bit as it stands each cycle
   ccr_way_alloc u_alloc (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .half_lock(s.ccr[BIT_HALF_LOCK]), // RULE_11
      .alloc_go(alloc_go),
      .way_valid(way_valid),
      .alloc_done(alloc_done),
      .alloc_way(alloc_way)
   );

   // invalidate-all sequencer
   ccr_inval_seq #(
      .NUM_SETS(NUM_SETS),
      .SET_W(SET_W)
   ) u_inval (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .start(inv_start),
      .busy(inv_busy),
      .clr_we(inv_clr),
      .clr_set(inval_clr_set),
      .done(inv_done)
   );

   // outputs
   assign cache_control_reg = s.ccr; // RULE_17
   assign bus_wr_req = (s.bus_st != BUS_IDLE);
   assign bus_wr_addr = s.bus_addr;
   assign bus_wr_data = s.bus_data;
   assign push_writeback = s.push_wb;
   assign push_invalidate = s.push_inv;
   assign inval_clr_we = inv_clr;

endmodule : ccr_cache_ctrl
`default_nettype wire

// File: sim/ccr_check_assertions.sv
// port assertions for the cache control register logic
`timescale 1ns/1ns
`default_nettype none
module ccr_check
   import ccr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic move_wr_en,
   input wire logic [31:0] move_wr_data,
   input wire logic dbg_wr_en,
   input wire logic [31:0] cache_control_reg,
   input wire logic acc_req,
   input wire logic acc_wr,
   input wire logic acc_stall,
   input wire logic acc_ack,
   input wire logic cache_lookup_en,
   input wire logic bus_wr_req,
   input wire logic alloc_ack,
   input wire logic alloc_done,
   input wire logic [1:0] alloc_way,
   input wire logic push_ack,
   input wire logic push_line_modified,
   input wire logic push_writeback,
   input wire logic push_invalidate,
   input wire logic inval_clr_we
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // a move write that sets the invalidate bit while idle
   sequence s_start;
      move_wr_en && !dbg_wr_en && move_wr_data[BIT_INVAL_ALL]
         && !cache_control_reg[BIT_INVAL_ALL];
   endsequence
   // the last clear pulse with no register write beside it
   sequence s_end;
      inval_clr_we ##1 (!inval_clr_we && !$past(move_wr_en)
         && !$past(dbg_wr_en));
   endsequence
   // register checks
   a_reset_clear: assert property ($rose(nrst) |->
      cache_control_reg == CCR_RESET) else $error("reset value wrong");
   a_reserved_zero: assert property (
      (cache_control_reg & ~CCR_WR_MASK) == 32'h0000_0000)
      else $error("reserved bit set");
   a_cache_off: assert property (!cache_control_reg[BIT_CACHE_ON] |->
      !cache_lookup_en && !alloc_ack) else $error("cache used while off");
   // access handshake
   a_pass_stall: assert property (cache_control_reg[BIT_INVAL_ALL]
      && acc_req |-> acc_stall) else $error("access not stalled by pass");
   a_direct_hold: assert property ($rose(bus_wr_req) && acc_req && acc_wr
      && !cache_control_reg[BIT_SB_ON] |-> !acc_ack [*4])
      else $error("direct write released early");
   // invalidation pass
   a_inval_start: assert property (s_start |=>
      cache_control_reg[BIT_INVAL_ALL] && !acc_ack ##1 inval_clr_we)
      else $error("pass did not start");
   a_inval_stall: assert property (inval_clr_we |->
      !acc_ack && !alloc_ack && !push_ack)
      else $error("access taken during pass");
   a_inval_end: assert property (s_end |->
      !cache_control_reg[BIT_INVAL_ALL]) else $error("bit not cleared");
   // push and allocation
   a_push_pulse: assert property (push_ack |=>
      push_writeback == $past(push_line_modified) && push_invalidate
      == !$past(cache_control_reg[BIT_KEEP_VALID]))
      else $error("push result wrong");
   a_alloc_done: assert property (alloc_ack |=> alloc_done)
      else $error("allocation not done");
   a_lock_ways: assert property (alloc_ack
      && cache_control_reg[BIT_HALF_LOCK] |=> alloc_way[1])
      else $error("locked way allocated");
endmodule : ccr_check
`default_nettype wire

// File: sim/ccr_bus_model.sv
// external bus responder that terminates each write after a delay
`timescale 1ns/1ns
`default_nettype none
module ccr_bus_model (
   input wire logic clk_sys,
   input wire logic bus_wr_req,
   input wire logic [31:0] bus_wr_addr,
   input wire logic [31:0] bus_wr_data,
   input wire logic [3:0] delay,
   output logic bus_wr_done,
   output logic [7:0] wr_count,
   output logic [31:0] last_addr,
   output logic [31:0] last_data
);
   int n;
   // one termination per write, then wait for the request to drop
   initial begin
      bus_wr_done = 1'h0;
      wr_count = 8'h00;
      last_addr = 32'h0000_0000;
      last_data = 32'h0000_0000;
      forever begin
         @(posedge clk_sys);
         #1;
         if (bus_wr_req === 1'h1) begin
            last_addr = bus_wr_addr;
            last_data = bus_wr_data;
            repeat (delay) @(posedge clk_sys);
            bus_wr_done <= 1'h1;
            wr_count <= wr_count + 8'h01;
            @(posedge clk_sys);
            bus_wr_done <= 1'h0;
            n = 0;
            #1;
            while (bus_wr_req === 1'h1 && n < 40) begin
               @(posedge clk_sys);
               #1;
               n++;
            end
         end
      end
   end
endmodule : ccr_bus_model
`default_nettype wire

// File: sim/test_ccr_cache_ctrl.sv
// self-checking bench for the cache control register logic
`timescale 1ns/1ns
`default_nettype none
module test_ccr_cache_ctrl;
   import ccr_pkg::*;
   logic clk_sys = 1'h0;
   logic nrst = 1'h0;
   logic move_wr_en = 1'h0;
   logic dbg_wr_en = 1'h0;
   logic acc_req = 1'h0;
   logic acc_wr = 1'h0;
   logic region_hit = 1'h0;
   logic alloc_req = 1'h0;
   logic push_req = 1'h0;
   logic push_line_modified = 1'h0;
   logic [31:0] move_wr_data = 32'h0000_0000;
   logic [31:0] dbg_wr_data = 32'h0000_0000;
   logic [31:0] acc_addr = 32'h0000_1000;
   logic [31:0] acc_data = 32'h0000_0000;
   logic [1:0] region_mode = 2'h0;
   logic [3:0] way_valid = 4'h0;
   logic [3:0] delay = 4'h1;
   logic [31:0] cache_control_reg, bus_wr_addr, bus_wr_data, last_addr;
   logic [31:0] last_data;
   logic acc_stall, acc_ack, cache_lookup_en, bus_wr_req, bus_wr_done;
   logic alloc_ack, alloc_done, push_ack, push_writeback, push_invalidate;
   logic inval_clr_we;
   logic [1:0] alloc_way, inval_clr_set;
   logic [7:0] wr_count;
   int mismatches = 0;
   int total_checks = 0;
   int nclr = 0;
   // lock flag, way valid bits, expected way
   logic [6:0] tab [16] = '{7'h00, 7'h18, 7'h15, 7'h2E, 7'h1F, 7'h3C,
      7'h3D, 7'h3E, 7'h3F, 7'h3C, 7'h42, 7'h53, 7'h7E, 7'h7F, 7'h4E, 7'h3D};

   ccr_cache_ctrl #(.NUM_SETS(4)) ccr_cache_ctrl_i (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .move_wr_en(move_wr_en),
      .move_wr_data(move_wr_data),
      .dbg_wr_en(dbg_wr_en),
      .dbg_wr_data(dbg_wr_data),
      .cache_control_reg(cache_control_reg),
      .acc_req(acc_req),
      .acc_wr(acc_wr),
      .acc_addr(acc_addr),
      .acc_data(acc_data),
      .region_hit(region_hit),
      .region_mode(region_mode),
      .acc_stall(acc_stall),
      .acc_ack(acc_ack),
      .cache_lookup_en(cache_lookup_en),
      .bus_wr_req(bus_wr_req),
      .bus_wr_addr(bus_wr_addr),
      .bus_wr_data(bus_wr_data),
      .bus_wr_done(bus_wr_done),
      .alloc_req(alloc_req),
      .way_valid(way_valid),
      .alloc_ack(alloc_ack),
      .alloc_done(alloc_done),
      .alloc_way(alloc_way),
      .push_req(push_req),
      .push_line_modified(push_line_modified),
      .push_ack(push_ack),
      .push_writeback(push_writeback),
      .push_invalidate(push_invalidate),
      .inval_clr_we(inval_clr_we),
      .inval_clr_set(inval_clr_set)
   );
   ccr_bus_model ccr_bus_model_i (
      .clk_sys(clk_sys),
      .bus_wr_req(bus_wr_req),
      .bus_wr_addr(bus_wr_addr),
      .bus_wr_data(bus_wr_data),
      .delay(delay),
      .bus_wr_done(bus_wr_done),
      .wr_count(wr_count),
      .last_addr(last_addr),
      .last_data(last_data)
   );

   // clock and clear pulse counter
   initial forever #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      #1;
      if (inval_clr_we === 1'h1) begin
         cmp(inval_clr_set, nclr[1:0]);
         nclr++;
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   // one register write strobe, move or debug
   task automatic wr_reg(input logic dbg, input logic [31:0] d);
      @(posedge clk_sys);
      move_wr_en <= !dbg;
      dbg_wr_en <= dbg;
      move_wr_data <= d;
      dbg_wr_data <= d;
      @(posedge clk_sys);
      move_wr_en <= 1'h0;
      dbg_wr_en <= 1'h0;
   endtask : wr_reg

   // one core access held until acked; returns stalled cycles
   task automatic acc(input logic wr, input logic hit, input logic [1:0] md,
      output int cyc, output logic lk);
      @(posedge clk_sys);
      acc_req <= 1'h1;
      acc_wr <= wr;
      region_hit <= hit;
      region_mode <= md;
      acc_addr <= acc_addr + 32'h0000_0004;
      acc_data <= ~acc_addr;
      cyc = 0;
      #1;
      while (acc_ack !== 1'h1) begin
         @(posedge clk_sys);
         #1;
         cyc++;
         if (cyc > 90) begin
            mismatches++;
            test_done;
         end
      end
      lk = cache_lookup_en;
      @(posedge clk_sys);
      acc_req <= 1'h0;
   endtask : acc

   task automatic t_regs;
      wr_reg(0, 32'hFEFF_FFFF);
      @(posedge clk_sys);
      #1;
      cmp(cache_control_reg, 32'hB800_0720);
      wr_reg(1, 32'h0000_0300);
      @(posedge clk_sys);
      #1;
      cmp(cache_control_reg, 32'h0000_0300);
      $display("test regs done");
   endtask : t_regs

   task automatic t_push;
      for (int i = 0; i < 4; i++) begin
         wr_reg(0, {1'h1, 2'h0, i[1], 28'h000_0000});
         @(posedge clk_sys);
         push_req <= 1'h1;
         push_line_modified <= i[0];
         @(posedge clk_sys);
         push_req <= 1'h0;
         #1;
         cmp({push_writeback, push_invalidate}, {i[0], !i[1]});
      end
      $display("test push done");
   endtask : t_push

   task automatic t_inval;
      int cyc;
      logic lk;
      nclr = 0;
      wr_reg(0, 32'h8100_0000);
      acc(0, 0, 2'h1, cyc, lk);
      @(posedge clk_sys);
      #1;
      cmp(cyc >= 4, 1'h1);
      cmp(nclr, 4);
      cmp(cache_control_reg, 32'h8000_0000);
      nclr = 0;
      wr_reg(0, 32'h8000_0000);
      repeat (10) @(posedge clk_sys);
      cmp(nclr, 0);
      $display("test inval done");
   endtask : t_inval

   task automatic t_alloc;
      for (int i = 0; i < 16; i++) begin
         wr_reg(0, tab[i][6] ? 32'h8800_0000 : 32'h8000_0000);
         @(posedge clk_sys);
         alloc_req <= 1'h1;
         way_valid <= tab[i][5:2];
         @(posedge clk_sys);
         alloc_req <= 1'h0;
         #1;
         cmp({alloc_done, alloc_way}, {1'h1, tab[i][1:0]});
      end
      $display("test alloc done");
   endtask : t_alloc

   task automatic t_writes;
      int cyc;
      int n;
      int s;
      logic lk;
      wr_reg(0, 32'h8000_0000);
      n = wr_count;
      acc(1, 0, 2'h1, cyc, lk);
      cmp(cyc >= 5, 1'h1);
      delay <= 4'h9;
      acc(1, 1, 2'h0, cyc, lk);
      cmp(cyc >= 10, 1'h1);
      acc(1, 1, 2'h3, cyc, lk);
      cmp(cyc >= 10, 1'h1);
      wr_reg(0, 32'h8000_0100);
      acc(1, 0, 2'h0, cyc, lk);
      cmp(cyc, 0);
      cmp(wr_count, n + 3);
      wr_reg(0, 32'hA000_0000);
      s = 0;
      for (int i = 0; i < 6; i++) begin
         acc(1, 1, 2'h0, cyc, lk);
         if (i < 4) cmp(cyc, 0);
         else s += cyc;
      end
      cmp(s > 0, 1'h1);
      acc(1, 1, 2'h2, cyc, lk);
      cmp(cyc >= 5, 1'h1);
      cmp(wr_count, n + 10);
      cmp(last_addr, acc_addr);
      cmp(last_data, ~(acc_addr - 32'h0000_0004));
      $display("test writes done");
   endtask : t_writes

   task automatic t_lookup;
      int cyc;
      logic lk;
      wr_reg(1, 32'h0000_0100);
      acc(0, 0, 2'h1, cyc, lk);
      cmp(lk, 1'h0);
      wr_reg(1, 32'h8000_0100);
      acc(0, 0, 2'h1, cyc, lk);
      cmp(lk, 1'h1);
      $display("test lookup done");
   endtask : t_lookup

   // reset, then each scenario in turn
   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1'h1;
      @(posedge clk_sys);
      #1;
      cmp(cache_control_reg, 32'h0000_0000);
      t_regs;
      t_push;
      t_inval;
      t_alloc;
      t_writes;
      t_lookup;
      test_done;
   end
endmodule : test_ccr_cache_ctrl

bind ccr_cache_ctrl ccr_check ccr_check_i (
   .clk_sys(clk_sys),
   .nrst(nrst),
   .move_wr_en(move_wr_en),
   .move_wr_data(move_wr_data),
   .dbg_wr_en(dbg_wr_en),
   .cache_control_reg(cache_control_reg),
   .acc_req(acc_req),
   .acc_wr(acc_wr),
   .acc_stall(acc_stall),
   .acc_ack(acc_ack),
   .cache_lookup_en(cache_lookup_en),
   .bus_wr_req(bus_wr_req),
   .alloc_ack(alloc_ack),
   .alloc_done(alloc_done),
   .alloc_way(alloc_way),
   .push_ack(push_ack),
   .push_line_modified(push_line_modified),
   .push_writeback(push_writeback),
   .push_invalidate(push_invalidate),
   .inval_clr_we(inval_clr_we)
);
`default_nettype wire
